// File: core/cbs_pkg.sv
// Package: constants and types of the bus cycle sequencer
`default_nettype none
package cbs_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Fixed addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] NMI_ENTRY = 16'h0066;
  localparam logic [ADDR_W-1:0] RESET_PC  = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts in T states
  // ----------------------------------------------------------------
  localparam logic [1:0] IO_AUTO_WAITS  = 2'h1;
  localparam logic [1:0] ACK_AUTO_WAITS = 2'h2;
  localparam logic [1:0] RESET_T_STATES = 2'h3;

  // ----------------------------------------------------------------
  // Machine cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CK_FETCH      = 3'h0,
    CK_MEM_RD     = 3'h1,
    CK_MEM_WR     = 3'h2,
    CK_IO_RD      = 3'h3,
    CK_IO_WR      = 3'h4,
    CK_INT_ACK    = 3'h5,
    CK_NMI_FETCH  = 3'h6,
    CK_HALT_FETCH = 3'h7
  } cbs_kind_t;

  // ----------------------------------------------------------------
  // T states, Gray along T1 T2 stall T3 T4
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_T1          = 3'h0,
    ST_T2          = 3'h1,
    ST_STALL_STATE = 3'h3,
    ST_T3          = 3'h2,
    ST_T4          = 3'h6,
    ST_BUS         = 3'h7,
    ST_RESET       = 3'h4
  } cbs_state_t;

endpackage : cbs_pkg
`default_nettype wire

// File: core/cbs_irq_if.sv
// Interface: interrupt link between sequencer and sampler
`timescale 1ns/1ns
`default_nettype none
interface cbs_irq_if;
  logic int_enable;
  logic nmi_take;
  logic nmi_pending;
  logic int_active;

  modport seq (
    output int_enable,
    output nmi_take,
    input  nmi_pending,
    input  int_active
  );

  modport smp (
    input  int_enable,
    input  nmi_take,
    output nmi_pending,
    output int_active
  );
endinterface : cbs_irq_if
`default_nettype wire

// File: core/cbs_irq_sampler.sv
// Module: interrupt request sampler of the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module cbs_irq_sampler (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic int_n,
  input  wire logic nmi_n,
  cbs_irq_if.smp    irq
);
  import cbs_pkg::*;

  logic nmi_prev;
  logic nmi_pending;
  logic next_nmi_prev;
  logic next_nmi_pending;

  // ----------------------------------------------------------------
  // Edge catch
  // ----------------------------------------------------------------
  always_comb begin
    next_nmi_prev    = nmi_n;
    next_nmi_pending = nmi_pending;
    if (irq.nmi_take)
      next_nmi_pending = 1'b0;
    if (nmi_prev && !nmi_n)
      next_nmi_pending = 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nmi_prev    <= 1'b1;
      nmi_pending <= 1'b0;
    end else begin
      nmi_prev    <= next_nmi_prev;
      nmi_pending <= next_nmi_pending;
    end
  end

  assign irq.nmi_pending = nmi_pending;
  // Level request, gated by the core's enable flag
  assign irq.int_active  = !int_n && irq.int_enable;

  a_nmi_edge_kept : assert property (
    @(posedge clock) disable iff (!reset_n)
    nmi_prev && !nmi_n |=> nmi_pending)
    else $error("nmi edge lost");

endmodule // cbs_irq_sampler
`default_nettype wire

// File: core/cbs_sequencer.sv
// Module: external bus cycle sequencer, top level
//
// How it works
// - Memory reads strobe exactly like fetch
// - Write request strobe follows stable address
// - Store strobe only inside stable data
// - I/O cycles get one automatic stall
// - Maskable request sampled at instruction end
// - Acknowledge uses I/O strobe, reads vector
// - Acknowledge cycle gets two automatic stalls
// - Non-maskable sampled same time, wins, unmaskable
// - NMI fetch ignores data, restarts 0066H
// - Bus request sampled in last state
// - Granted bus floats on next edge
// - Halt repeats no-op fetches until interrupt
// - Halt output held until interrupt taken
// - Reset floats buses, controls inactive
// - Three idle states after reset release
// - Reset clears program counter to 0000
// - Stopped clock keeps all state
// - Restarted clock resumes where it stopped
// - Stall repeats while wait input low
// - Grant output shows floated bus
// - First-cycle with I/O strobe means acknowledge
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  output var  logic [cbs_pkg::ADDR_W-1:0] addr,
  output var  logic                      addr_oe,
  input  wire logic [cbs_pkg::DATA_W-1:0] data_in,
  output var  logic [cbs_pkg::DATA_W-1:0] data_out,
  output var  logic                      data_oe,
  output var  logic                      memory_request_n,
  output var  logic                      io_request_n,
  output var  logic                      read_n,
  output var  logic                      store_n,
  output var  logic                      strobe_oe,
  output var  logic                      first_cycle_n,
  output var  logic                      halt_n,
  input  wire logic                      wait_n,
  input  wire logic                      int_n,
  input  wire logic                      nmi_n,
  input  wire logic                      bus_request_n,
  output var  logic                      bus_grant_n,
  input  wire logic                      cmd_valid,
  input  wire cbs_pkg::cbs_kind_t        cmd_kind,
  input  wire logic [cbs_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [cbs_pkg::DATA_W-1:0] cmd_wdata,
  input  wire logic                      instr_end,
  input  wire logic                      halt_exec,
  input  wire logic                      int_enable,
  input  wire logic                      pc_load,
  input  wire logic [cbs_pkg::ADDR_W-1:0] pc_value,
  output var  logic                      cmd_taken,
  output var  logic                      cycle_done,
  output var  cbs_pkg::cbs_kind_t        cycle_kind,
  output var  logic [cbs_pkg::DATA_W-1:0] read_data,
  output var  logic [cbs_pkg::ADDR_W-1:0] pc
);
  import cbs_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic reset_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      reset_n  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      reset_n  <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sampler
  // ----------------------------------------------------------------
  cbs_irq_if irq ();

  cbs_irq_sampler cbs_irq_sampler_inst (
    .clock   (clock),
    .reset_n (reset_n),
    .int_n   (int_n),
    .nmi_n   (nmi_n),
    .irq     (irq)
  );

  logic nmi_take;
  assign irq.nmi_take   = nmi_take;
  assign irq.int_enable = int_enable;

  // ----------------------------------------------------------------
  // Cycle kind helpers
  // ----------------------------------------------------------------
  function automatic logic m1_kind(input cbs_kind_t k);
    return k inside {CK_FETCH, CK_NMI_FETCH, CK_HALT_FETCH, CK_INT_ACK};
  endfunction

  function automatic logic mem_kind(input cbs_kind_t k);
    return k inside {CK_FETCH, CK_NMI_FETCH, CK_HALT_FETCH,
                     CK_MEM_RD, CK_MEM_WR};
  endfunction

  function automatic logic rd_kind(input cbs_kind_t k);
    return k inside {CK_FETCH, CK_NMI_FETCH, CK_HALT_FETCH,
                     CK_MEM_RD, CK_IO_RD};
  endfunction

  function automatic logic io_kind(input cbs_kind_t k);
    return k inside {CK_IO_RD, CK_IO_WR};
  endfunction

  function automatic logic wr_kind(input cbs_kind_t k);
    return k inside {CK_MEM_WR, CK_IO_WR};
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  cbs_state_t        state;
  cbs_kind_t         kind;
  logic [1:0]        auto_left;
  logic [1:0]        reset_cnt;
  logic              bound;
  cbs_state_t        next_state;
  cbs_kind_t         next_kind;
  logic [1:0]        next_auto_left;
  logic [1:0]        next_reset_cnt;
  logic              next_bound;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_data_out;
  logic [DATA_W-1:0] next_read_data;
  logic              next_halted;
  logic              next_done;
  logic              next_taken;
  logic              next_memory_request_n_n;
  logic              next_io_request_n_n;
  logic              next_rd_n;
  logic              next_st_n;
  logic              next_m1_n;
  logic              next_data_oe;
  logic              next_bus_oe;
  logic              next_grant_n;
  logic              cycle_end;
  logic              decide;
  logic              bnd;
  logic              irq_accept;
  logic              in_body;
  logic              in_cycle;
  logic [ADDR_W-1:0] eff_pc;
  logic              halted;

  assign halted     = !halt_n;
  assign cycle_kind = kind;
  // Core jumps are ignored while the reset states run
  assign eff_pc = (pc_load && state != ST_RESET) ? pc_value : pc;

  always_comb begin
    next_state     = state;
    next_kind      = kind;
    next_auto_left = auto_left;
    next_reset_cnt = reset_cnt;
    next_bound     = bound;
    next_pc        = eff_pc;
    next_addr      = addr;
    next_data_out  = data_out;
    next_read_data = read_data;
    next_halted    = halted;
    next_done      = 1'b0;
    next_taken     = 1'b0;
    nmi_take       = 1'b0;
    irq_accept     = 1'b0;
    cycle_end      = 1'b0;
    decide         = 1'b0;
    bnd            = bound;
    unique case (state)
      ST_RESET: begin
        next_reset_cnt = reset_cnt + 2'h1;
        if (reset_cnt == RESET_T_STATES - 2'h1)
          decide = 1'b1;
      end
      ST_T1: begin
        next_state = ST_T2;
      end
      ST_T2: begin
        if (auto_left != 2'h0 || !wait_n)
          next_state = ST_STALL_STATE;
        else
          next_state = ST_T3;
      end
      ST_STALL_STATE: begin
        if (auto_left != 2'h0)
          next_auto_left = auto_left - 2'h1;
        if (next_auto_left != 2'h0 || !wait_n)
          next_state = ST_STALL_STATE;
        else
          next_state = ST_T3;
      end
      ST_T3: begin
        if (kind inside {CK_FETCH, CK_MEM_RD, CK_IO_RD, CK_INT_ACK})
          next_read_data = data_in;
        if (m1_kind(kind))
          next_state = ST_T4;
        else
          cycle_end = 1'b1;
      end
      ST_T4: begin
        cycle_end = 1'b1;
      end
      ST_BUS: begin
        if (bus_request_n)
          decide = 1'b1;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase

    if (cycle_end) begin
      next_done  = 1'b1;
      bnd        = instr_end || kind == CK_HALT_FETCH;
      next_bound = bnd;
      if (instr_end && halt_exec)
        next_halted = 1'b1;
      // Bus request seen in last state
      if (!bus_request_n)
        next_state = ST_BUS;
      else
        decide = 1'b1;
    end

    if (decide) begin
      next_state = ST_T1;
      next_addr  = eff_pc;
      if (bnd && irq.nmi_pending) begin
        next_kind  = CK_NMI_FETCH;
        nmi_take   = 1'b1;
        irq_accept = 1'b1;
        next_pc    = NMI_ENTRY;
      end else if (bnd && irq.int_active) begin
        next_kind  = CK_INT_ACK;
        irq_accept = 1'b1;
      end else if (bnd && next_halted) begin
        next_kind = CK_HALT_FETCH;
      end else if (!bnd && cmd_valid) begin
        next_kind     = cmd_kind;
        next_addr     = cmd_addr;
        next_data_out = cmd_wdata;
        next_taken    = 1'b1;
      end else begin
        next_kind = CK_FETCH;
        next_pc   = eff_pc + 16'h0001;
      end
      if (irq_accept)
        next_halted = 1'b0;
      if (io_kind(next_kind))
        next_auto_left = IO_AUTO_WAITS;
      else if (next_kind == CK_INT_ACK)
        next_auto_left = ACK_AUTO_WAITS;
      else
        next_auto_left = 2'h0;
    end

    // Pin levels follow the state being entered
    in_body  = next_state inside {ST_T2, ST_STALL_STATE, ST_T3};
    in_cycle = in_body || next_state == ST_T1;
    next_memory_request_n_n  = !(mem_kind(next_kind) && in_body);
    next_rd_n    = !(rd_kind(next_kind) && in_body);
    next_st_n    = !(wr_kind(next_kind)
                     && next_state inside {ST_T2, ST_STALL_STATE});
    next_data_oe = wr_kind(next_kind) && in_cycle;
    next_io_request_n_n  = !((io_kind(next_kind) && in_body)
                     || (next_kind == CK_INT_ACK
                         && next_state inside {ST_STALL_STATE, ST_T3}));
    next_m1_n    = !(m1_kind(next_kind) && in_cycle);
    next_bus_oe  = !(next_state inside {ST_BUS, ST_RESET});
    next_grant_n = next_state != ST_BUS;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Static flops: a stopped clock loses nothing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state            <= ST_RESET;
      kind             <= CK_FETCH;
      auto_left        <= 2'h0;
      reset_cnt        <= 2'h0;
      bound            <= 1'b1;
      pc               <= RESET_PC;
      addr             <= RESET_PC;
      data_out         <= DATA_RST;
      read_data        <= DATA_RST;
      halt_n           <= 1'b1;
      cycle_done       <= 1'b0;
      cmd_taken        <= 1'b0;
      memory_request_n <= 1'b1;
      io_request_n     <= 1'b1;
      read_n           <= 1'b1;
      store_n          <= 1'b1;
      first_cycle_n    <= 1'b1;
      data_oe          <= 1'b0;
      addr_oe          <= 1'b0;
      strobe_oe        <= 1'b0;
      bus_grant_n      <= 1'b1;
    end else begin
      state            <= next_state;
      kind             <= next_kind;
      auto_left        <= next_auto_left;
      reset_cnt        <= next_reset_cnt;
      bound            <= next_bound;
      pc               <= next_pc;
      addr             <= next_addr;
      data_out         <= next_data_out;
      read_data        <= next_read_data;
      halt_n           <= !next_halted;
      cycle_done       <= next_done;
      cmd_taken        <= next_taken;
      memory_request_n <= next_memory_request_n_n;
      io_request_n     <= next_io_request_n_n;
      read_n           <= next_rd_n;
      store_n          <= next_st_n;
      first_cycle_n    <= next_m1_n;
      data_oe          <= next_data_oe;
      addr_oe          <= next_bus_oe;
      strobe_oe        <= next_bus_oe;
      bus_grant_n      <= next_grant_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_read_strobes : assert property (
    state inside {ST_T2, ST_STALL_STATE, ST_T3}
      && kind inside {CK_FETCH, CK_MEM_RD}
      |-> !memory_request_n && !read_n)
    else $error("read strobes missing");

  a_write_addr_first : assert property (
    $fell(memory_request_n) && kind == CK_MEM_WR
      |-> $past(addr_oe) && $stable(addr))
    else $error("write request before address");

  a_store_data_window : assert property (
    !store_n |-> data_oe && $past(data_oe)
      ##1 data_oe && $stable(data_out))
    else $error("store outside data window");

  a_io_one_stall : assert property (
    state == ST_T2 && io_kind(kind) |=> state == ST_STALL_STATE)
    else $error("io stall missing");

  a_int_sampled : assert property (
    cycle_end && instr_end && bus_request_n && !irq.nmi_pending
      && irq.int_active |=> kind == CK_INT_ACK && state == ST_T1)
    else $error("interrupt not accepted");

  a_ack_marks : assert property (
    !io_request_n && !first_cycle_n |-> kind == CK_INT_ACK)
    else $error("bad acknowledge marking");

  a_ack_two_stalls : assert property (
    state == ST_T2 && kind == CK_INT_ACK
      |=> state == ST_STALL_STATE [*2])
    else $error("acknowledge stalls short");

  a_nmi_first : assert property (
    cycle_end && instr_end && bus_request_n && irq.nmi_pending
      |=> kind == CK_NMI_FETCH)
    else $error("nmi lost priority");

  a_nmi_entry : assert property (
    state == ST_T1 && kind == CK_NMI_FETCH |-> pc == NMI_ENTRY)
    else $error("nmi entry wrong");

  a_bus_float : assert property (
    cycle_end && !bus_request_n
      |=> !bus_grant_n && !addr_oe && !data_oe && !strobe_oe)
    else $error("bus not floated");

  a_halt_held : assert property (
    $rose(halt_n) |-> $past(irq_accept))
    else $error("halt left without interrupt");

  a_halt_fetch : assert property (
    cycle_end && instr_end && halt_exec && bus_request_n
      && !irq.nmi_pending && !irq.int_active
      |=> kind == CK_HALT_FETCH && !halt_n)
    else $error("halt no-op missing");

  a_reset_idle : assert property (
    $rose(reset_n) |-> state == ST_RESET [*3] ##1 state == ST_T1)
    else $error("reset idle count wrong");

  a_stall_on_wait : assert property (
    state inside {ST_T2, ST_STALL_STATE} && !wait_n
      |=> state == ST_STALL_STATE)
    else $error("wait ignored");

endmodule // cbs_sequencer
`default_nettype wire

// File: dv/cbs_bus_model.sv
// Partner model: memory, I/O port and interrupting device
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_model #(
  parameter logic [7:0] VECTOR = 8'hc3
) (
  input  wire logic [cbs_pkg::ADDR_W-1:0] addr,
  input  wire logic                      clock,
  input  wire logic                      memory_request_n,
  input  wire logic                      io_request_n,
  input  wire logic                      read_n,
  input  wire logic                      first_cycle_n,
  input  wire logic [31:0]               slow,
  output var  logic [cbs_pkg::DATA_W-1:0] data_in,
  output var  logic                      wait_n
);
  import cbs_pkg::*;
  logic [DATA_W-1:0] last = 8'h00;
  int                cnt  = 0;
  logic              req;

  assign req = !memory_request_n || !io_request_n;
  always_comb begin
    if (!io_request_n && !first_cycle_n) begin
      data_in = VECTOR;
    end else if (!memory_request_n && !read_n) begin
      data_in = addr[7:0] ^ 8'h5a;
    end else if (!io_request_n && !read_n) begin
      data_in = addr[7:0] ^ 8'h3c;
    end else begin
      // Released bus must never echo the old byte
      data_in = ~last;
    end
  end
  assign wait_n = !(req && cnt < slow);
  always @(posedge clock) begin
    last <= data_in;
    cnt <= req ? cnt + 1 : 0;
  end
endmodule // cbs_bus_model
`default_nettype wire

// File: dv/cbs_sequencer_test.sv
// Testbench: directed scenarios for the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer_test;
  import cbs_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              run   = 1'b1;
  logic [ADDR_W-1:0] addr, cmd_addr, pc, pc_value;
  logic [DATA_W-1:0] data_in, data_out, cmd_wdata, read_data;
  logic              addr_oe, data_oe, strobe_oe, wait_n, cmd_taken;
  logic              memory_request_n, io_request_n, read_n, store_n;
  logic              first_cycle_n, halt_n, bus_grant_n, cycle_done;
  logic              int_n, nmi_n, bus_request_n, cmd_valid, instr_end;
  logic              halt_exec, int_enable, pc_load;
  cbs_kind_t         cmd_kind, cycle_kind;
  int                slow, errors, checks_done, n;
  logic [15:0]       snap;

  // Clock parks low while run is off
  always #2 if (run || clock) clock = ~clock;

  cbs_sequencer cbs_sequencer_inst (.clock, .rst_n, .addr, .addr_oe,
    .data_in, .data_out, .data_oe, .memory_request_n, .io_request_n,
    .read_n, .store_n, .strobe_oe, .first_cycle_n, .halt_n, .wait_n,
    .int_n, .nmi_n, .bus_request_n, .bus_grant_n, .cmd_valid, .cmd_kind,
    .cmd_addr, .cmd_wdata, .instr_end, .halt_exec, .int_enable, .pc_load,
    .pc_value, .cmd_taken, .cycle_done, .cycle_kind, .read_data, .pc);
  cbs_bus_model cbs_bus_model_inst (.addr, .clock, .memory_request_n,
    .io_request_n, .read_n, .first_cycle_n, .slow, .data_in, .wait_n);

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic limit(input int k, input string what);
    if (k >= 40) begin
      errors++;
      $display("BAD %s expected event seen timeout", what);
      final_report();
    end
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 40; k++) begin
      tick();
      if (cycle_done === 1'b1) break;
    end
    limit(k, "cycle_done");
  endtask

  task automatic run_cmd(input cbs_kind_t kind, input logic [15:0] a,
                         input logic [7:0] wd, output int mlo, output int ilo);
    int k;
    mlo = 0;
    ilo = 0;
    cmd_kind = kind;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    instr_end = 1'b0;
    for (k = 0; k < 40 && cmd_taken !== 1'b1; k++) tick();
    limit(k, "cmd_taken");
    cmd_valid = 1'b0;
    instr_end = 1'b1;
    for (k = 0; k < 40; k++) begin
      tick();
      if (cycle_done === 1'b1) break;
      mlo += (memory_request_n === 1'b0);
      ilo += (io_request_n === 1'b0);
      if (!memory_request_n || !io_request_n)
        check_val("cmd_addr_bus", a, addr);
      if (store_n === 1'b0)
        check_val("store_data", {8'h01, wd}, {7'h0, data_oe, data_out});
    end
    limit(k, "cmd cycle_done");
  endtask

  task automatic test_transfers();
    cbs_kind_t kinds[4] = '{CK_MEM_RD, CK_MEM_WR, CK_IO_RD, CK_IO_WR};
    int m;
    int i;
    for (int k = 0; k < 4; k++) begin
      slow = (k < 2) ? 2 : 0;
      run_cmd(kinds[k], 16'(16'h12a0 + k), 8'(8'h96 - k), m, i);
      check_val("memory_request_n_cycles", (k < 2) ? 16'h4 : 16'h0, m[15:0]);
      check_val("io_request_n_cycles", (k < 2) ? 16'h0 : 16'h3, i[15:0]);
      if (k == 0) check_val("mem_rd", 16'h00fa, {8'h0, read_data});
      if (k == 2) check_val("io_rd", 16'h009e, {8'h0, read_data});
    end
    slow = 0;
    $display("done transfers");
  endtask

  task automatic test_ack();
    int k;
    int lo;
    int_enable = 1'b1;
    int_n = 1'b0;
    for (k = 0; k < 40 && !(io_request_n === 1'b0); k++) tick();
    limit(k, "ack");
    int_n = 1'b1;
    int_enable = 1'b0;
    check_val("ack_first", 16'h0, {15'h0, first_cycle_n});
    check_val("ack_kind", CK_INT_ACK, cycle_kind);
    for (lo = 0; lo < 40 && io_request_n === 1'b0; lo++) tick();
    check_val("ack_io_request_n", 16'h3, lo[15:0]);
    wait_done();
    check_val("vector", 16'h00c3, {8'h0, read_data});
    $display("done ack");
  endtask

  task automatic test_bus();
    int k;
    bus_request_n = 1'b0;
    for (k = 0; k < 40 && bus_grant_n !== 1'b0; k++) tick();
    limit(k, "grant");
    check_val("grant_float", 16'h0, {13'h0, addr_oe, data_oe, strobe_oe});
    repeat (4) tick();
    check_val("grant_held", 16'h0, {15'h0, bus_grant_n});
    // Core jump while the bus is lent
    pc_load = 1'b1;
    pc_value = 16'h4321;
    tick();
    pc_load = 1'b0;
    bus_request_n = 1'b1;
    for (k = 0; k < 40 && first_cycle_n !== 1'b0; k++) tick();
    limit(k, "bus return");
    check_val("bus_back", 16'h3, {14'h0, addr_oe, bus_grant_n});
    check_val("jump_addr", 16'h4321, addr);
    check_val("jump_pc", 16'h4322, pc);
    $display("done bus");
  endtask

  task automatic test_halt();
    int k;
    halt_exec = 1'b1;
    for (k = 0; k < 40 && halt_n !== 1'b0; k++) tick();
    limit(k, "halt");
    halt_exec = 1'b0;
    repeat (12) tick();
    check_val("halted", {12'h0, CK_HALT_FETCH, 1'b0},
              {12'h0, cycle_kind, halt_n});
    for (k = 0; k < 40 && first_cycle_n !== 1'b1; k++) tick();
    limit(k, "halt T4");
    // Stop low inside T4, as a clock controller would
    snap = addr ^ {12'h0, halt_n, memory_request_n, read_n, first_cycle_n};
    run = 1'b0;
    #40;
    check_val("stopped", snap, addr ^ {12'h0, halt_n,
              memory_request_n, read_n, first_cycle_n});
    run = 1'b1;
    tick();
    check_val("resumed", 16'h0, {14'h0, first_cycle_n, halt_n});
    // Wake by interrupt, edge well ahead
    int_enable = 1'b1;
    int_n = 1'b0;
    nmi_n = 1'b0;
    for (k = 0; k < 40 && cycle_kind === CK_HALT_FETCH; k++) tick();
    limit(k, "halt exit");
    int_n = 1'b1;
    int_enable = 1'b0;
    check_val("nmi_kind", CK_NMI_FETCH, cycle_kind);
    wait_done();
    check_val("nmi_entry", NMI_ENTRY, addr);
    check_val("nmi_pc", NMI_ENTRY + 16'h0001, pc);
    check_val("halt_off", 16'h1, {15'h0, halt_n});
    nmi_n = 1'b1;
    $display("done halt");
  endtask

  initial begin
    {cmd_addr, pc_value, cmd_wdata, slow, errors, checks_done} = '0;
    {cmd_valid, halt_exec, int_enable, pc_load} = '0;
    {int_n, nmi_n, bus_request_n, instr_end} = '1;
    cmd_kind = CK_MEM_RD;
    repeat (10) tick();
    check_val("reset_out", 16'h007f, {6'h0, addr_oe, data_oe, strobe_oe,
              memory_request_n, io_request_n, read_n, store_n,
              first_cycle_n, halt_n, bus_grant_n});
    repeat (2) tick();
    rst_n = 1'b1;
    for (n = 0; n < 40 && first_cycle_n !== 1'b0; n++) tick();
    limit(n, "first fetch");
    check_val("reset_gap", 16'h1, {15'h0, n >= 5});
    check_val("reset_pc", RESET_PC, addr);
    $display("done reset");
    test_transfers();
    test_ack();
    test_bus();
    test_halt();
    final_report();
  end
endmodule // cbs_sequencer_test
`default_nettype wire
